// ### arsc_defines.svh
/*
 Constants for the read-sector command block: task-file addresses,
 command codes, status and error bit positions, geometry and counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef ARSC_DEFINES_SVH
`define ARSC_DEFINES_SVH
// Task-file register addresses
`define ARSC_A_DATA 3'h0
`define ARSC_A_ERR 3'h1
`define ARSC_A_CNT 3'h2
`define ARSC_A_NUM 3'h3
`define ARSC_A_CYLLO 3'h4
`define ARSC_A_CYLHI 3'h5
`define ARSC_A_DH 3'h6
`define ARSC_A_CMD 3'h7
// Command codes
`define ARSC_CMD_NATMAX 8'h27
`define ARSC_CMD_READ 8'h20
`define ARSC_CMD_READ_NR 8'h21
// Error register bits
`define ARSC_ERR_UNC 6
`define ARSC_ERR_ABT 2
// Device/head bits
`define ARSC_DH_LBA 6
`define ARSC_DH_RESET 8'hA0
// Sector geometry and counts
`define ARSC_WORD_LAST 8'hFF
`define ARSC_CNT_FULL 9'h100
`define ARSC_CNT_ONE 9'h001
`define ARSC_SPT 8'h3F
`define ARSC_SEC_FIRST 8'h01
`define ARSC_HEAD_LAST 4'hF
// Status register bits
`define ARSC_ST_BSY 7
`define ARSC_ST_RDY 6
`define ARSC_ST_DSC 4
`define ARSC_ST_DRQ 3
`define ARSC_ST_ERR 0
`endif

// ### arsc_pkg.sv
/*
 Types for the read-sector command block: task-file byte group and
 command state encoding. Assumes the defines header is available.
*/
package arsc_pkg;
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] num;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
   } arsc_tf_t;

   typedef enum logic [1:0] {
      ARSC_IDLE = 2'b00,
      ARSC_REQ = 2'b01,
      ARSC_XFER = 2'b10
   } arsc_state_t;
endpackage

// ### arsc_read_cmd.sv
/*
 Command execution for the native-max query and the 28-bit read-sectors
 command behind an ATA task file. Host strobes arrive from the pins and
 are synchronised here; address and write data must stay stable while a
 strobe is asserted. The media side runs on this clock and streams one
 sector of 16-bit words per request.
*/
// Contract
// - Code 27h returns native max, ignores limits
// - Native max split over current and HOB bytes
// - Codes 20h/21h read sectors to host
// - Data passes as 16-bit words per access
// - Uncorrectable error stops at failing sector
// - Sector count zero means 256 sectors
// - CHS start from sector, cylinder, head
// - LBA start is 28 bits across registers
// - Retry bit ignored, both codes identical
// - Remaining count left in sector count
// - Last transferred address left in registers
// - LBA bits 8-15 low, 16-23 high cylinder
`timescale 1ns/1ps
`include "arsc_defines.svh"
`default_nettype none
module arsc_read_cmd
   import arsc_pkg::*;
#(
   parameter logic [47:0] NATIVE_MAX = 48'h0000_0FFF_FFFF
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic [2:0] TF_ADDR_I,
   input wire logic TF_WR_I,
   input wire logic TF_RD_I,
   input wire logic HOB_I,
   input wire logic [15:0] TF_WDATA_I,
   output logic [15:0] TF_RDATA_O,
   output logic MED_REQ_O,
   output logic [27:0] MED_ADDR_O,
   output logic MED_LBA_O,
   output logic MED_READY_O,
   input wire logic MED_VALID_I,
   input wire logic [15:0] MED_DATA_I,
   input wire logic MED_UNC_I
);
   ////////////////////////////////////////////////////////////////////////
   // Address stepping
   function automatic logic [27:0] next_addr(input logic lba, input logic [27:0] a);
      logic [27:0] r;
      r = a;
      if (lba) begin
         r = a + 28'h0000001;
      end else if (a[7:0] >= `ARSC_SPT) begin
         r[7:0] = `ARSC_SEC_FIRST;
         if (a[27:24] == `ARSC_HEAD_LAST) begin
            r[27:24] = 4'h0;
            r[23:8] = a[23:8] + 16'h0001;
         end else begin
            r[27:24] = a[27:24] + 4'h1;
         end
      end else begin
         r[7:0] = a[7:0] + 8'h01;
      end
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Strobe synchronisers
   logic [2:0] wr_s_r, wr_s_nxt, rd_s_r, rd_s_nxt;
   logic wr_lv_r, wr_lv_nxt, rd_lv_r, rd_lv_nxt;
   logic wr_pulse, rd_pulse;

   // Stage one feeds stage two only; a level counts once two and three agree
   always_comb begin
      wr_s_nxt = {wr_s_r[1:0], TF_WR_I};
      rd_s_nxt = {rd_s_r[1:0], TF_RD_I};
      wr_lv_nxt = wr_lv_r;
      rd_lv_nxt = rd_lv_r;
      if (wr_s_r[1] == wr_s_r[2]) begin
         wr_lv_nxt = wr_s_r[2];
      end
      if (rd_s_r[1] == rd_s_r[2]) begin
         rd_lv_nxt = rd_s_r[2];
      end
      wr_pulse = CE_I && wr_lv_nxt && !wr_lv_r;
      rd_pulse = CE_I && rd_lv_nxt && !rd_lv_r;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         wr_s_r <= 3'h0;
         rd_s_r <= 3'h0;
         wr_lv_r <= 1'b0;
         rd_lv_r <= 1'b0;
      end else if (CE_I) begin
         wr_s_r <= wr_s_nxt;
         rd_s_r <= rd_s_nxt;
         wr_lv_r <= wr_lv_nxt;
         rd_lv_r <= rd_lv_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Task file and command engine
   arsc_state_t st_r, st_nxt;
   arsc_tf_t tf_r, tf_nxt, hob_r, hob_nxt;
   logic [7:0] dh_r, dh_nxt, err_r, err_nxt;
   logic errf_r, errf_nxt, full_r, full_nxt, req_r, req_nxt;
   logic [27:0] addr_r, addr_nxt;
   logic [8:0] rem_r, rem_nxt;
   logic [7:0] wcnt_r, wcnt_nxt;
   logic [15:0] word_r, word_nxt, rdata_r, rdata_nxt;
   logic [7:0] status;
   logic [8:0] rem_dec;
   logic accept, bsy;

   assign bsy = (st_r != ARSC_IDLE) && !full_r;
   assign accept = (st_r == ARSC_XFER) && !full_r && MED_VALID_I;
   assign rem_dec = rem_r - `ARSC_CNT_ONE;

   always_comb begin
      status = 8'h00;
      status[`ARSC_ST_BSY] = bsy;
      status[`ARSC_ST_RDY] = 1'b1;
      status[`ARSC_ST_DSC] = 1'b1;
      status[`ARSC_ST_DRQ] = full_r;
      status[`ARSC_ST_ERR] = errf_r;
   end

   always_comb begin
      st_nxt = st_r;
      tf_nxt = tf_r;
      hob_nxt = hob_r;
      dh_nxt = dh_r;
      err_nxt = err_r;
      errf_nxt = errf_r;
      full_nxt = full_r;
      req_nxt = 1'b0;
      addr_nxt = addr_r;
      rem_nxt = rem_r;
      wcnt_nxt = wcnt_r;
      word_nxt = word_r;
      rdata_nxt = rdata_r;
      // Task file is frozen while a command runs so results are not torn
      if (wr_pulse && st_r == ARSC_IDLE && !full_r) begin
         unique case (TF_ADDR_I)
            `ARSC_A_CNT: begin
               hob_nxt.cnt = tf_r.cnt;
               tf_nxt.cnt = TF_WDATA_I[7:0];
            end
            `ARSC_A_NUM: begin
               hob_nxt.num = tf_r.num;
               tf_nxt.num = TF_WDATA_I[7:0];
            end
            `ARSC_A_CYLLO: begin
               hob_nxt.cyl_lo = tf_r.cyl_lo;
               tf_nxt.cyl_lo = TF_WDATA_I[7:0];
            end
            `ARSC_A_CYLHI: begin
               hob_nxt.cyl_hi = tf_r.cyl_hi;
               tf_nxt.cyl_hi = TF_WDATA_I[7:0];
            end
            `ARSC_A_DH: dh_nxt = TF_WDATA_I[7:0];
            `ARSC_A_CMD: begin
               err_nxt = 8'h00;
               errf_nxt = 1'b0;
               unique case (TF_WDATA_I[7:0])
                  `ARSC_CMD_NATMAX: begin
                     tf_nxt.num = NATIVE_MAX[7:0];
                     tf_nxt.cyl_lo = NATIVE_MAX[15:8];
                     tf_nxt.cyl_hi = NATIVE_MAX[23:16];
                     hob_nxt.num = NATIVE_MAX[31:24];
                     hob_nxt.cyl_lo = NATIVE_MAX[39:32];
                     hob_nxt.cyl_hi = NATIVE_MAX[47:40];
                  end
                  `ARSC_CMD_READ, `ARSC_CMD_READ_NR: begin
                     rem_nxt = (tf_r.cnt == 8'h00) ? `ARSC_CNT_FULL : {1'b0, tf_r.cnt};
                     addr_nxt = {dh_r[3:0], tf_r.cyl_hi, tf_r.cyl_lo, tf_r.num};
                     st_nxt = ARSC_REQ;
                  end
                  default: begin
                     err_nxt[`ARSC_ERR_ABT] = 1'b1;
                     errf_nxt = 1'b1;
                  end
               endcase
            end
            default: ;
         endcase
      end
      if (rd_pulse) begin
         unique case (TF_ADDR_I)
            `ARSC_A_DATA: begin
               rdata_nxt = word_r;
               full_nxt = 1'b0;
            end
            `ARSC_A_ERR: rdata_nxt = {8'h00, err_r};
            `ARSC_A_CNT: rdata_nxt = {8'h00, HOB_I ? hob_r.cnt : tf_r.cnt};
            `ARSC_A_NUM: rdata_nxt = {8'h00, HOB_I ? hob_r.num : tf_r.num};
            `ARSC_A_CYLLO: rdata_nxt = {8'h00, HOB_I ? hob_r.cyl_lo : tf_r.cyl_lo};
            `ARSC_A_CYLHI: rdata_nxt = {8'h00, HOB_I ? hob_r.cyl_hi : tf_r.cyl_hi};
            `ARSC_A_DH: rdata_nxt = {8'h00, dh_r};
            `ARSC_A_CMD: rdata_nxt = {8'h00, status};
            default: ;
         endcase
      end
      unique case (st_r)
         ARSC_IDLE: ;
         ARSC_REQ: begin
            req_nxt = 1'b1;
            wcnt_nxt = 8'h00;
            st_nxt = ARSC_XFER;
         end
         ARSC_XFER: begin
            if (MED_UNC_I) begin
               st_nxt = ARSC_IDLE;
               tf_nxt.cnt = rem_r[7:0];
               err_nxt[`ARSC_ERR_UNC] = 1'b1;
               errf_nxt = 1'b1;
            end else if (accept) begin
               word_nxt = MED_DATA_I;
               full_nxt = 1'b1;
               wcnt_nxt = wcnt_r + 8'h01;
               if (wcnt_r == `ARSC_WORD_LAST) begin
                  rem_nxt = rem_dec;
                  tf_nxt.cnt = rem_dec[7:0];
                  tf_nxt.num = addr_r[7:0];
                  tf_nxt.cyl_lo = addr_r[15:8];
                  tf_nxt.cyl_hi = addr_r[23:16];
                  dh_nxt[3:0] = addr_r[27:24];
                  if (rem_r == `ARSC_CNT_ONE) begin
                     st_nxt = ARSC_IDLE;
                  end else begin
                     addr_nxt = next_addr(dh_r[`ARSC_DH_LBA], addr_r);
                     st_nxt = ARSC_REQ;
                  end
               end
            end
         end
         default: st_nxt = ARSC_IDLE;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_r <= ARSC_IDLE;
         tf_r <= '0;
         hob_r <= '0;
         dh_r <= `ARSC_DH_RESET;
         err_r <= 8'h00;
         errf_r <= 1'b0;
         full_r <= 1'b0;
         req_r <= 1'b0;
         addr_r <= 28'h0000000;
         rem_r <= 9'h000;
         wcnt_r <= 8'h00;
         word_r <= 16'h0000;
         rdata_r <= 16'h0000;
      end else if (CE_I) begin
         st_r <= st_nxt;
         tf_r <= tf_nxt;
         hob_r <= hob_nxt;
         dh_r <= dh_nxt;
         err_r <= err_nxt;
         errf_r <= errf_nxt;
         full_r <= full_nxt;
         req_r <= req_nxt;
         addr_r <= addr_nxt;
         rem_r <= rem_nxt;
         wcnt_r <= wcnt_nxt;
         word_r <= word_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign TF_RDATA_O = rdata_r;
   assign MED_REQ_O = req_r;
   assign MED_ADDR_O = addr_r;
   assign MED_LBA_O = dh_r[`ARSC_DH_LBA];
   // Single word stage: media stalls until the host drains the data register
   assign MED_READY_O = (st_r == ARSC_XFER) && !full_r && CE_I;
endmodule
`default_nettype wire

// ### arsc_read_cmd_sva.sv
/*
 Assertion checker for the read-sector command block.
 Assumes it sees only the top module ports; bound at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module arsc_read_cmd_chk (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic TF_RD_I,
   input wire logic [15:0] TF_RDATA_O,
   input wire logic MED_REQ_O,
   input wire logic [27:0] MED_ADDR_O,
   input wire logic MED_LBA_O,
   input wire logic MED_READY_O,
   input wire logic MED_VALID_I,
   input wire logic MED_UNC_I
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   ////////////////////////////////////////////////////////////////////////////////
   property p_req_pulse;
      MED_REQ_O |=> !MED_REQ_O [*8];
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request pulse too long");
   property p_req_ready;
      MED_REQ_O |=> ##[0:100] MED_READY_O;
   endproperty
   a_req_ready: assert property (p_req_ready) else $error("no word taken after request");
   property p_ready_ce;
      !CE_I |-> !MED_READY_O;
   endproperty
   a_ready_ce: assert property (p_ready_ce) else $error("ready while frozen");
   property p_take_word;
      MED_VALID_I && MED_READY_O |=> !MED_READY_O;
   endproperty
   a_take_word: assert property (p_take_word) else $error("second word taken unread");
   property p_addr_hold;
      MED_READY_O && $past(MED_READY_O) |-> $stable(MED_ADDR_O);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved mid sector");
   property p_lba_hold;
      MED_REQ_O |=> $stable(MED_LBA_O) [*3];
   endproperty
   a_lba_hold: assert property (p_lba_hold) else $error("address form moved");
   // Four quiet cycles cover the host's shortest strobe spacing
   property p_unc_stop;
      MED_UNC_I && MED_READY_O |=> (!MED_REQ_O && !MED_READY_O) [*4];
   endproperty
   a_unc_stop: assert property (p_unc_stop) else $error("transfer went on after error");
   property p_rd_hold;
      !TF_RD_I [*7] |=> $stable(TF_RDATA_O);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed unread");
endmodule
bind arsc_read_cmd arsc_read_cmd_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I),
   .TF_RD_I(TF_RD_I), .TF_RDATA_O(TF_RDATA_O), .MED_REQ_O(MED_REQ_O),
   .MED_ADDR_O(MED_ADDR_O), .MED_LBA_O(MED_LBA_O), .MED_READY_O(MED_READY_O),
   .MED_VALID_I(MED_VALID_I), .MED_UNC_I(MED_UNC_I));
`default_nettype wire

// ### arsc_host_model.sv
/*
 Host controller model: task-file strobe cycles.
 Assumes strobe timing held four clocks or more each way.
*/
`timescale 1ns/1ps
`default_nettype none
module arsc_host_model (
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   output logic [2:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic hob_o,
   output logic [15:0] wdata_o
);
   initial begin
      addr_o = 3'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      hob_o = 1'b0;
      wdata_o = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= {8'h00, d};
      wr_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      wr_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      // Stale data must not look valid
      wdata_o <= ~{8'h00, d};
   endtask
   task automatic rd(input logic [2:0] a, input logic h, output logic [15:0] q);
      @(posedge clk_i);
      addr_o <= a;
      hob_o <= h;
      rd_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      q = rdata_i;
      rd_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ### arsc_tb.sv
/*
 Self-checking bench for the read-sector command block.
 Assumes the host model and a prompt media stream driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import arsc_pkg::*;
   localparam logic [47:0] NMAX = 48'h1234_5678_9ABC;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, mvalid = 1'b0, munc = 1'b0, serve = 1'b1;
   logic wr, rd, hob, mreq, mlba, mready;
   logic [2:0] addr;
   logic [15:0] wdata, rdata, q, mdata = 16'h0000;
   logic [27:0] maddr;
   logic [7:0] widx = 8'h00, nidx;
   int bad_count = 0, checked = 0;
   always #25 clk = ~clk;
   arsc_read_cmd #(.NATIVE_MAX(NMAX)) DUT (.CLK_I(clk), .RST_I(rst), .CE_I(ce),
      .TF_ADDR_I(addr), .TF_WR_I(wr), .TF_RD_I(rd), .HOB_I(hob), .TF_WDATA_I(wdata),
      .TF_RDATA_O(rdata), .MED_REQ_O(mreq), .MED_ADDR_O(maddr), .MED_LBA_O(mlba),
      .MED_READY_O(mready), .MED_VALID_I(mvalid), .MED_DATA_I(mdata), .MED_UNC_I(munc));
   arsc_host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .hob_o(hob), .wdata_o(wdata));
   always @(posedge clk) begin
      // A word may be taken in the request cycle itself
      nidx = ((rst || mreq === 1'b1) ? 8'h00 : widx) + {7'h00, mvalid && mready === 1'b1};
      widx <= nidx;
      mvalid <= serve;
      mdata <= serve ? {maddr[7:0], nidx} : ~mdata;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_drq;
      for (int i = 0; i < 30; i++) begin
         host.rd(3'h7, 1'b0, q);
         if (q[3] === 1'b1) return;
      end
      bad_count++;
      report_and_stop();
   endtask
   task automatic cmd(input logic [47:0] p);
      for (int i = 0; i < 6; i++) host.wr(3'(i + 2), p[47 - 8 * i -: 8]);
   endtask
   task automatic regs(input logic [31:0] e, input logic [3:0] h, input logic [7:0] st);
      for (int i = 0; i < 4; i++) begin
         host.rd(3'(i + 2), 1'b0, q);
         chk("taskreg", e[31 - 8 * i -: 8], q[7:0]);
      end
      host.rd(3'h6, 1'b0, q);
      chk("head", h, q[3:0]);
      host.rd(3'h7, 1'b0, q);
      chk("status", st, q[7:0]);
   endtask
   task automatic sector(input logic [27:0] a, input logic l, input int first, input int last);
      for (int i = first; i < last; i++) begin
         wait_drq();
         if (i == first) chk("maddr", a, maddr);
         if (i == first) chk("mlba", l, mlba);
         host.rd(3'h0, 1'b0, q);
         chk("word", {a[7:0], 8'(i)}, q);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      regs(32'h0000_0000, 4'h0, 8'h50);
      host.rd(3'h6, 1'b0, q);
      chk("devhead", 8'hA0, q[7:0]);
   endtask
   task automatic t_abort;
      host.wr(3'h7, 8'h55);
      host.rd(3'h1, 1'b0, q);
      chk("error", 8'h04, q[7:0]);
      host.rd(3'h7, 1'b0, q);
      chk("status", 8'h51, q[7:0]);
   endtask
   task automatic t_natmax;
      host.wr(3'h7, 8'h27);
      for (int h = 0; h < 2; h++) begin
         for (int i = 0; i < 3; i++) begin
            host.rd(3'(3 + i), h[0], q);
            chk("natmax", NMAX[24 * h + 8 * i +: 8], q[7:0]);
         end
      end
   endtask
   task automatic t_lba;
      cmd(48'h02_FF_CD_AB_EA_20);
      sector(28'hAABCDFF, 1'b1, 0, 256);
      sector(28'hAABCE00, 1'b1, 0, 256);
      regs(32'h00_00_CE_AB, 4'hA, 8'h50);
   endtask
   task automatic t_chs;
      cmd(48'h02_3F_02_01_AF_21);
      sector(28'hF01023F, 1'b0, 0, 256);
      sector(28'h0010301, 1'b0, 0, 256);
      regs(32'h00_01_03_01, 4'h0, 8'h50);
   endtask
   task automatic t_unc;
      cmd(48'h00_10_00_00_E0_20);
      sector(28'h0000010, 1'b1, 0, 256);
      sector(28'h0000011, 1'b1, 0, 4);
      @(posedge clk);
      serve <= 1'b0;
      sector(28'h0000011, 1'b1, 4, 5);
      for (int i = 0; i < 20 && mready !== 1'b1; i++) @(negedge clk);
      if (mready !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
      // Frozen clock enable must hold off the media stage
      @(posedge clk);
      ce <= 1'b0;
      repeat (3) @(negedge clk);
      chk("frozen_ready", 1'b0, mready);
      @(posedge clk);
      ce <= 1'b1;
      @(negedge clk);
      chk("thawed_ready", 1'b1, mready);
      @(posedge clk);
      munc <= 1'b1;
      @(posedge clk);
      munc <= 1'b0;
      regs(32'hFF_10_00_00, 4'h0, 8'h51);
      host.rd(3'h1, 1'b0, q);
      chk("error", 8'h40, q[7:0]);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_abort();
      t_natmax();
      t_lba();
      t_chs();
      t_unc();
      report_and_stop();
   end
endmodule
`default_nettype wire
